/* File: vhr_pkg.sv */
// Package: constants, types and register map of the vertex header readback block
package vhr_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DWORD_W = 32;
  localparam int ROW_W = 256;
  localparam int REG_ADDR_W = 8;
  localparam int ROW_IDX_W = 6;
  localparam int RTAI_W = 11;
  localparam int PW_W = 11;
  localparam int UCC_W = 8;
  localparam int VP_OUT_W = 4;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MAXVP = 8'h04;
  localparam logic [7:0] REG_UCMASK = 8'h08;
  localparam logic [7:0] REG_RDLEN = 8'h0C;
  localparam logic [7:0] REG_DISTROW = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_VCOUNT = 8'h18;
  localparam logic [7:0] REG_HCOUNT = 8'h1C;

  // ----------------------------------------
  // Register fields and reset values
  // ----------------------------------------
  localparam int CTRL_GEOM_EN_BIT = 0;
  localparam int CTRL_CLIP_EN_BIT = 1;
  localparam int CTRL_DIST_EN_BIT = 2;
  localparam int STAT_LEN_ERR_BIT = 0;
  localparam int STAT_VP_CLAMP_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;
  localparam logic [31:0] MAXVP_RST = 32'h0000000F;
  localparam logic [7:0] UCMASK_RST = 8'hFF;
  localparam logic [5:0] RDLEN_RST = 6'h01;
  localparam logic [5:0] DISTROW_RST = 6'h01;

  // ----------------------------------------
  // Header layout
  // ----------------------------------------
  localparam int RTAI_DW = 1;
  localparam int VP_DW = 2;
  localparam int PW_DW = 3;
  localparam int PW_LSB = 8;
  localparam int UCC_LSB = 0;
  localparam int POSX_DW = 4;
  localparam int POSY_DW = 5;
  localparam int POSZ_DW = 6;
  localparam int RHW_DW = 7;
  localparam logic [5:0] HDR_ROW = 6'h00;
  localparam logic [5:0] MAX_READ_LEN = 6'h3F;
  localparam logic [31:0] VP_FIXED_MAX = 32'h0000000F;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR_REQ = 3'b001,
    ST_HDR_WAIT = 3'b010,
    ST_DIST_REQ = 3'b011,
    ST_DIST_WAIT = 3'b100,
    ST_OUT = 3'b101
  } vhr_state_e;

  typedef enum logic {
    PT_PRE_CLIP = 1'b0,
    PT_POST_CLIP = 1'b1
  } vhr_point_e;

  typedef struct packed {
    logic [RTAI_W-1:0] rtai;
    logic [DWORD_W-1:0] vpRaw;
    logic [PW_W-1:0] pointWidth;
    logic [UCC_W-1:0] clipCodes;
    logic [DWORD_W-1:0] posX;
    logic [DWORD_W-1:0] posY;
    logic [DWORD_W-1:0] posZ;
    logic [DWORD_W-1:0] rhw;
  } vhr_hdr_s;

endpackage : vhr_pkg

/* File: vhr_header_unpack.sv */
// Header unpacker: splits the first row of a vertex entry into its fields
`timescale 1ns/1ps
`default_nettype none
module vhr_header_unpack
  import vhr_pkg::*;
(
  input wire logic [ROW_W-1:0] row,
  output vhr_hdr_s hdr
);

  // ----------------------------------------
  // Field extraction, reserved bits dropped
  // ----------------------------------------
  assign hdr.rtai = row[RTAI_DW*DWORD_W +: RTAI_W];
  assign hdr.vpRaw = row[VP_DW*DWORD_W +: DWORD_W];
  assign hdr.pointWidth = row[PW_DW*DWORD_W+PW_LSB +: PW_W];
  assign hdr.clipCodes = row[PW_DW*DWORD_W+UCC_LSB +: UCC_W];
  assign hdr.posX = row[POSX_DW*DWORD_W +: DWORD_W];
  assign hdr.posY = row[POSY_DW*DWORD_W +: DWORD_W];
  assign hdr.posZ = row[POSZ_DW*DWORD_W +: DWORD_W];
  assign hdr.rhw = row[RHW_DW*DWORD_W +: DWORD_W];

endmodule : vhr_header_unpack
`default_nettype wire

/* File: vhr_vp_check.sv */
// Viewport index range check with zero substitution
`timescale 1ns/1ps
`default_nettype none
module vhr_vp_check
  import vhr_pkg::*;
#(
  parameter int OUT_W = 4
)
(
  input wire logic [DWORD_W-1:0] vpIn,
  input wire logic [DWORD_W-1:0] vpLimit,
  output logic [OUT_W-1:0] vpOut,
  output logic outOfRange
);

  // ----------------------------------------
  // Compare against limit
  // ----------------------------------------
  assign outOfRange = (vpIn > vpLimit);
  assign vpOut = outOfRange ? '0 : vpIn[OUT_W-1:0];

endmodule : vhr_vp_check
`default_nettype wire

/* File: vhr_readback.sv */
// Vertex header readback engine for the points before and after the clipper
//
// Contract
// - Pre-clip: read 256-bit header of every entry
// - Optional pre-clip read of clip distance row
// - Post-clip: read header only for clipper vertices
// - Array index is dword 1 bits 10:0
// - Viewport index dword 2, picks one of 16
// - Viewport read for every vertex toward clipper
// - Geometry enabled: check against max, else zero
// - Geometry disabled: check against 0..15
// - Post-clip viewport: low 4 bits, no check
// - Point width dword 3 bits 18:8, points only
// - Clip codes ANDed with user clip mask
// - Clip codes ignored for clipper vertices
// - Dwords 4..6 hold X, Y, Z floats
// - Dword 7 holds reciprocal W float
// - Only dwords 0..7 interpreted, rest opaque
// - Read length at most 63 rows
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module vhr_readback
  import vhr_pkg::*;
#(
  parameter int HANDLE_W = 10,
  parameter int COUNT_W = 16
)
(
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [DWORD_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DWORD_W-1:0] regRdata,
  // Incoming vertex stream
  input wire logic inValid,
  output logic inReady,
  input wire logic [HANDLE_W-1:0] inHandle,
  input wire logic inPoint,
  input wire logic inClipGen,
  input wire logic inPointTopo,
  // Vertex store read port
  output logic memReqValid,
  output logic [HANDLE_W-1:0] memReqHandle,
  output logic [ROW_IDX_W-1:0] memReqRow,
  input wire logic memRspValid,
  input wire logic [ROW_W-1:0] memRspData,
  // Outgoing vertex stream
  output logic outValid,
  input wire logic outReady,
  output logic [HANDLE_W-1:0] outHandle,
  output logic outPoint,
  output logic outHdrValid,
  output logic [RTAI_W-1:0] outRtai,
  output logic [VP_OUT_W-1:0] outVpIndex,
  output logic [PW_W-1:0] outPointWidth,
  output logic [UCC_W-1:0] outClipCodes,
  output logic [DWORD_W-1:0] outPosX,
  output logic [DWORD_W-1:0] outPosY,
  output logic [DWORD_W-1:0] outPosZ,
  output logic [DWORD_W-1:0] outRhw,
  output logic outDistValid,
  output logic [ROW_W-1:0] outClipDist,
  output logic [ROW_IDX_W-1:0] outReadLen
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  vhr_state_e state_reg;
  vhr_state_e state_next;
  logic [2:0] ctrl_reg;
  logic [DWORD_W-1:0] maxVp_reg;
  logic [UCC_W-1:0] ucMask_reg;
  logic [ROW_IDX_W-1:0] readLen_reg;
  logic [ROW_IDX_W-1:0] distRow_reg;
  logic lenErr_reg;
  logic vpClamp_reg;
  logic [COUNT_W-1:0] vtxCount_reg;
  logic [COUNT_W-1:0] hdrCount_reg;
  logic [HANDLE_W-1:0] handle_reg;
  logic point_reg;
  logic pointTopo_reg;
  logic hdrValid_reg;
  logic [RTAI_W-1:0] rtai_reg;
  logic [VP_OUT_W-1:0] vp_reg;
  logic [PW_W-1:0] pw_reg;
  logic [UCC_W-1:0] ucc_reg;
  logic [DWORD_W-1:0] posX_reg;
  logic [DWORD_W-1:0] posY_reg;
  logic [DWORD_W-1:0] posZ_reg;
  logic [DWORD_W-1:0] rhw_reg;
  logic distValid_reg;
  logic [ROW_W-1:0] dist_reg;
  logic [ROW_IDX_W-1:0] row_reg;
  logic [ROW_IDX_W-1:0] row_next;
  logic [DWORD_W-1:0] rdata_reg;
  logic [DWORD_W-1:0] rdata_next;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire logic wrCtrl = regWr && (regAddr == REG_CTRL);
  wire logic wrMaxVp = regWr && (regAddr == REG_MAXVP);
  wire logic wrUcMask = regWr && (regAddr == REG_UCMASK);
  wire logic wrRdLen = regWr && (regAddr == REG_RDLEN);
  wire logic wrDistRow = regWr && (regAddr == REG_DISTROW);
  wire logic wrStatus = regWr && (regAddr == REG_STATUS);
  wire logic geomEn = ctrl_reg[CTRL_GEOM_EN_BIT];
  wire logic clipEn = ctrl_reg[CTRL_CLIP_EN_BIT];
  wire logic distEn = ctrl_reg[CTRL_DIST_EN_BIT];

  // Read length above the limit is clamped and flagged
  wire logic lenTooLong = (regWdata > {{(DWORD_W-ROW_IDX_W){1'b0}}, MAX_READ_LEN});
  wire logic [ROW_IDX_W-1:0] readLenWr = lenTooLong ? MAX_READ_LEN
                                                    : regWdata[ROW_IDX_W-1:0];
  wire logic lenErrSet = wrRdLen && lenTooLong;
  wire logic lenErrClr = wrStatus && regWdata[STAT_LEN_ERR_BIT];
  wire logic busy = (state_reg != ST_IDLE);

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  wire logic [DWORD_W-1:0] statusWord = {{(DWORD_W-3){1'b0}}, busy, vpClamp_reg, lenErr_reg};
  always_comb begin
    case (regAddr)
      REG_CTRL: rdata_next = {{(DWORD_W-3){1'b0}}, ctrl_reg};
      REG_MAXVP: rdata_next = maxVp_reg;
      REG_UCMASK: rdata_next = {{(DWORD_W-UCC_W){1'b0}}, ucMask_reg};
      REG_RDLEN: rdata_next = {{(DWORD_W-ROW_IDX_W){1'b0}}, readLen_reg};
      REG_DISTROW: rdata_next = {{(DWORD_W-ROW_IDX_W){1'b0}}, distRow_reg};
      REG_STATUS: rdata_next = statusWord;
      REG_VCOUNT: rdata_next = {{(DWORD_W-COUNT_W){1'b0}}, vtxCount_reg};
      REG_HCOUNT: rdata_next = {{(DWORD_W-COUNT_W){1'b0}}, hdrCount_reg};
      default: rdata_next = '0;
    endcase
  end

  // ----------------------------------------
  // Header field processing
  // ----------------------------------------
  vhr_hdr_s hdr;
  logic [VP_OUT_W-1:0] vpChecked;
  logic vpOutOfRange;

  vhr_header_unpack u_unpack (
    .row(memRspData),
    .hdr(hdr)
  );

  // Limit depends on whether the geometry function runs
  wire logic [DWORD_W-1:0] vpLimit = geomEn ? maxVp_reg : VP_FIXED_MAX;

  vhr_vp_check #(
    .OUT_W(VP_OUT_W)
  ) u_vp_check (
    .vpIn(hdr.vpRaw),
    .vpLimit(vpLimit),
    .vpOut(vpChecked),
    .outOfRange(vpOutOfRange)
  );

  wire logic isPre = (point_reg == PT_PRE_CLIP);
  wire logic [VP_OUT_W-1:0] vpSel = isPre ? vpChecked : hdr.vpRaw[VP_OUT_W-1:0];
  wire logic [UCC_W-1:0] uccSel = isPre ? (hdr.clipCodes & ucMask_reg) : '0;
  wire logic [PW_W-1:0] pwSel = pointTopo_reg ? hdr.pointWidth : '0;
  wire logic hdrDone = (state_reg == ST_HDR_WAIT) && memRspValid;
  wire logic distDone = (state_reg == ST_DIST_WAIT) && memRspValid;
  wire logic vpClampSet = hdrDone && isPre && vpOutOfRange;
  wire logic vpClampClr = wrStatus && regWdata[STAT_VP_CLAMP_BIT];

  // ----------------------------------------
  // Vertex sequencing
  // ----------------------------------------
  wire logic accept = inValid && inReady;
  // Post-clip pass-through vertices skip readback
  wire logic needHdr = (inPoint == PT_PRE_CLIP) || (inClipGen && clipEn);
  // Distance row must fall inside the read length
  wire logic distOk = distEn && (distRow_reg != HDR_ROW) && (distRow_reg < readLen_reg);
  wire logic leaving = outValid && outReady;

  assign inReady = (state_reg == ST_IDLE);
  assign memReqValid = (state_reg == ST_HDR_REQ) || (state_reg == ST_DIST_REQ);
  assign outValid = (state_reg == ST_OUT);

  always_comb begin
    state_next = state_reg;
    row_next = row_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = needHdr ? ST_HDR_REQ : ST_OUT;
          row_next = HDR_ROW;
        end
      end
      ST_HDR_REQ: begin
        state_next = ST_HDR_WAIT;
      end
      ST_HDR_WAIT: begin
        if (memRspValid) begin
          if (isPre && distOk) begin
            state_next = ST_DIST_REQ;
            row_next = distRow_reg;
          end else begin
            state_next = ST_OUT;
          end
        end
      end
      ST_DIST_REQ: begin
        state_next = ST_DIST_WAIT;
      end
      ST_DIST_WAIT: begin
        if (memRspValid) begin
          state_next = ST_OUT;
        end
      end
      ST_OUT: begin
        if (outReady) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      row_reg <= HDR_ROW;
    end else begin
      state_reg <= state_next;
      row_reg <= row_next;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RST;
      maxVp_reg <= MAXVP_RST;
      ucMask_reg <= UCMASK_RST;
    end else begin
      if (wrCtrl) ctrl_reg <= regWdata[2:0];
      if (wrMaxVp) maxVp_reg <= regWdata;
      if (wrUcMask) ucMask_reg <= regWdata[UCC_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      readLen_reg <= RDLEN_RST;
      distRow_reg <= DISTROW_RST;
    end else begin
      if (wrRdLen) readLen_reg <= readLenWr;
      if (wrDistRow) distRow_reg <= regWdata[ROW_IDX_W-1:0];
    end
  end

  // ----------------------------------------
  // Status flags and counters
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lenErr_reg <= 1'b0;
      vpClamp_reg <= 1'b0;
    end else begin
      lenErr_reg <= lenErrSet | (lenErr_reg & ~lenErrClr);
      vpClamp_reg <= vpClampSet | (vpClamp_reg & ~vpClampClr);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      vtxCount_reg <= '0;
      hdrCount_reg <= '0;
    end else begin
      if (leaving) vtxCount_reg <= vtxCount_reg + 1'b1;
      if (hdrDone) hdrCount_reg <= hdrCount_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= regRd ? rdata_next : '0;
    end
  end

  // ----------------------------------------
  // Captured vertex and header fields
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      handle_reg <= '0;
      point_reg <= PT_PRE_CLIP;
      pointTopo_reg <= 1'b0;
    end else if (accept) begin
      handle_reg <= inHandle;
      point_reg <= inPoint;
      pointTopo_reg <= inPointTopo;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hdrValid_reg <= 1'b0;
      rtai_reg <= '0;
      vp_reg <= '0;
      pw_reg <= '0;
      ucc_reg <= '0;
    end else if (accept) begin
      hdrValid_reg <= 1'b0;
      rtai_reg <= '0;
      vp_reg <= '0;
      pw_reg <= '0;
      ucc_reg <= '0;
    end else if (hdrDone) begin
      hdrValid_reg <= 1'b1;
      rtai_reg <= hdr.rtai;
      vp_reg <= vpSel;
      pw_reg <= pwSel;
      ucc_reg <= uccSel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      posX_reg <= '0;
      posY_reg <= '0;
      posZ_reg <= '0;
      rhw_reg <= '0;
    end else if (hdrDone) begin
      posX_reg <= hdr.posX;
      posY_reg <= hdr.posY;
      posZ_reg <= hdr.posZ;
      rhw_reg <= hdr.rhw;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      distValid_reg <= 1'b0;
      dist_reg <= '0;
    end else if (accept) begin
      distValid_reg <= 1'b0;
    end else if (distDone) begin
      distValid_reg <= 1'b1;
      dist_reg <= memRspData;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regRdata = rdata_reg;
  assign memReqHandle = handle_reg;
  assign memReqRow = row_reg;
  assign outHandle = handle_reg;
  assign outPoint = point_reg;
  assign outHdrValid = hdrValid_reg;
  assign outRtai = rtai_reg;
  assign outVpIndex = vp_reg;
  assign outPointWidth = pw_reg;
  assign outClipCodes = ucc_reg;
  assign outPosX = posX_reg;
  assign outPosY = posY_reg;
  assign outPosZ = posZ_reg;
  assign outRhw = rhw_reg;
  assign outDistValid = distValid_reg;
  assign outClipDist = dist_reg;
  assign outReadLen = readLen_reg;

endmodule : vhr_readback
`default_nettype wire

/* File: vhr_store_model.sv */
// Vertex store model that answers row reads of the readback block
`timescale 1ns/1ps
`default_nettype none
module vhr_store_model
  import vhr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic memReqValid,
  input wire logic [ROW_IDX_W-1:0] memReqRow,
  input wire logic [ROW_W-1:0] hdrRow,
  input wire logic [ROW_W-1:0] distRow,
  input wire logic [3:0] latency,
  output logic memRspValid,
  output logic [ROW_W-1:0] memRspData
);
  // ----------------------------------------
  // Delayed answer, data toggles while idle
  // ----------------------------------------
  logic busy;
  logic [3:0] waitCnt;
  logic [ROW_IDX_W-1:0] rowReg;
  always_ff @(posedge core_clk) begin
    memRspValid <= 1'b0;
    memRspData <= ~memRspData;
    if (srst) begin
      busy <= 1'b0;
      memRspData <= '0;
    end else if (memReqValid) begin
      busy <= 1'b1;
      waitCnt <= latency;
      rowReg <= memReqRow;
    end else if (busy && waitCnt <= 4'h1) begin
      busy <= 1'b0;
      memRspValid <= 1'b1;
      memRspData <= (rowReg == HDR_ROW) ? hdrRow : distRow;
    end else if (busy) begin
      waitCnt <= waitCnt - 4'h1;
    end
  end
endmodule : vhr_store_model
`default_nettype wire

/* File: vhr_readback_asserts.sv */
// Port checker of the vertex header readback block
`timescale 1ns/1ps
`default_nettype none
module vhr_readback_asserts
  import vhr_pkg::*;
#(
  parameter int HANDLE_W = 10,
  parameter int COUNT_W = 16
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic inValid,
  input wire logic inReady,
  input wire logic [HANDLE_W-1:0] inHandle,
  input wire logic inPoint,
  input wire logic inClipGen,
  input wire logic inPointTopo,
  input wire logic memReqValid,
  input wire logic [HANDLE_W-1:0] memReqHandle,
  input wire logic [ROW_IDX_W-1:0] memReqRow,
  input wire logic memRspValid,
  input wire logic [ROW_W-1:0] memRspData,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [HANDLE_W-1:0] outHandle,
  input wire logic outPoint,
  input wire logic outHdrValid,
  input wire logic [RTAI_W-1:0] outRtai,
  input wire logic [VP_OUT_W-1:0] outVpIndex,
  input wire logic [PW_W-1:0] outPointWidth,
  input wire logic [UCC_W-1:0] outClipCodes,
  input wire logic [DWORD_W-1:0] outPosX,
  input wire logic [DWORD_W-1:0] outPosY,
  input wire logic [DWORD_W-1:0] outPosZ,
  input wire logic [DWORD_W-1:0] outRhw,
  input wire logic outDistValid,
  input wire logic [ROW_W-1:0] outClipDist
);
  // ----------------------------------------
  // Tracking of the vertex in flight
  // ----------------------------------------
  logic ptReg;
  logic topoReg;
  logic [HANDLE_W-1:0] handleReg;
  logic [ROW_IDX_W-1:0] rowReg;
  logic [ROW_W-1:0] hdrSeen;
  wire accept = inValid && inReady;
  wire [3:0] vpRsp = memRspData[67:64];
  always_ff @(posedge core_clk) begin
    if (accept) begin
      ptReg <= inPoint;
      topoReg <= inPointTopo;
      handleReg <= inHandle;
    end
    if (memReqValid) begin
      rowReg <= memReqRow;
    end
    if (memRspValid && rowReg == HDR_ROW) begin
      hdrSeen <= memRspData;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_hdr_row_req: assert property (accept && !inPoint |=> memReqValid && memReqRow == HDR_ROW)
    else $error("header row not requested");
  a_pre_answer: assert property (accept && !inPoint |-> ##[2:40] outValid)
    else $error("pre-clip vertex not forwarded");
  a_pass_no_read: assert property (accept && inPoint && !inClipGen |=> outValid && !outHdrValid && !memReqValid)
    else $error("pass-through vertex read or late");
  a_post_vp_raw: assert property (memRspValid && ptReg |=> outVpIndex == $past(vpRsp) && outClipCodes == 8'h00)
    else $error("post-clip viewport or codes wrong");
  a_rtai_field: assert property (outValid && outHdrValid |-> outRtai == hdrSeen[42:32])
    else $error("array index wrong");
  a_pos_words: assert property (outValid && outHdrValid |-> outPosX == hdrSeen[159:128] && outPosY == hdrSeen[191:160] && outPosZ == hdrSeen[223:192])
    else $error("position words wrong");
  a_rhw_word: assert property (outValid && outHdrValid |-> outRhw == hdrSeen[255:224])
    else $error("reciprocal w wrong");
  a_point_width: assert property (outValid && outHdrValid |-> outPointWidth == (topoReg ? hdrSeen[114:104] : 11'h000))
    else $error("point width wrong");
  a_dist_pre_only: assert property (memReqValid && memReqRow != HDR_ROW |-> !ptReg)
    else $error("distance row read after clip");
  a_dist_data: assert property (memRspValid && rowReg != HDR_ROW |=> outValid && outDistValid && outClipDist == $past(memRspData))
    else $error("distance row not forwarded");
  a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outHandle) && $stable(outVpIndex))
    else $error("output changed while stalled");
  a_handle_fwd: assert property (outValid |-> outHandle == handleReg)
    else $error("handle not forwarded");
  a_req_handle: assert property (memReqValid |-> memReqHandle == handleReg)
    else $error("request handle wrong");
  a_point_fwd: assert property (outValid |-> outPoint == ptReg)
    else $error("point kind not forwarded");
  c_stall: cover property (outValid && !outReady);
  c_dist: cover property (outValid && outDistValid);
  c_post_hdr: cover property (outValid && outHdrValid && ptReg);
endmodule : vhr_readback_asserts
bind vhr_readback vhr_readback_asserts #(.HANDLE_W(HANDLE_W), .COUNT_W(COUNT_W)) chk_u (
  .core_clk, .srst, .inValid, .inReady, .inHandle, .inPoint, .inClipGen, .inPointTopo,
  .memReqValid, .memReqHandle, .memReqRow, .memRspValid, .memRspData, .outValid, .outReady,
  .outHandle, .outPoint, .outHdrValid, .outRtai, .outVpIndex, .outPointWidth, .outClipCodes,
  .outPosX, .outPosY, .outPosZ, .outRhw, .outDistValid, .outClipDist
);
`default_nettype wire

/* File: vhr_readback_tb.sv */
// Self-checking testbench of the vertex header readback block
`timescale 1ns/1ps
`default_nettype none
module vhr_readback_tb;
  import vhr_pkg::*;
  localparam logic [31:0] DW1 = 32'hFFFF_F7A5;
  localparam logic [31:0] DW3 = 32'hFFF8_2B5A;
  logic core_clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [7:0] regAddr = 8'h00, ucMask = 8'hFF;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic inValid = 1'b0, inPoint = 1'b0, inClipGen = 1'b0, inPointTopo = 1'b0, outReady = 1'b1;
  logic [9:0] inHandle = 10'h000, memReqHandle, outHandle;
  logic [255:0] hdrRow = '0, distRow = {8{32'h3F80_1234}}, memRspData, outClipDist;
  logic [3:0] latency = 4'h1, outVpIndex;
  logic [5:0] rdLen = 6'h01, memReqRow, outReadLen;
  logic inReady, memReqValid, memRspValid, outValid, outPoint, outHdrValid, outDistValid;
  logic [10:0] outRtai, outPointWidth;
  logic [7:0] outClipCodes;
  logic [31:0] outPosX, outPosY, outPosZ, outRhw;
  int failCount = 0, comparisons = 0, cycles = 0;
  vhr_readback dut_u (.core_clk, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .inValid, .inReady, .inHandle, .inPoint, .inClipGen, .inPointTopo, .memReqValid,
    .memReqHandle, .memReqRow, .memRspValid, .memRspData, .outValid, .outReady, .outHandle,
    .outPoint, .outHdrValid, .outRtai, .outVpIndex, .outPointWidth, .outClipCodes, .outPosX,
    .outPosY, .outPosZ, .outRhw, .outDistValid, .outClipDist, .outReadLen);
  vhr_store_model store_u (.core_clk, .srst, .memReqValid, .memReqRow, .hdrRow, .distRow,
    .latency, .memRspValid, .memRspData);
  always #5 core_clk = ~core_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wrapUp();
    if (failCount == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrapUp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    check(regRdata, e);
    @(posedge core_clk);
  endtask : rd
  task automatic vtx(input logic pt, input logic cg, input logic topo, input logic [31:0] vp,
      input logic eHdr, input logic [3:0] eVp, input logic eDist, input int stall);
    int n;
    n = 0;
    hdrRow <= {32'h3E80_0000, 32'h3F00_0000, 32'h4000_0000, 32'h3F80_0000, DW3, vp, DW1,
      32'hA5A5_5A5A};
    inHandle <= inHandle + 10'h001;
    inPoint <= pt;
    inClipGen <= cg;
    inPointTopo <= topo;
    inValid <= 1'b1;
    outReady <= (stall == 0);
    @(posedge core_clk);
    while (inReady !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    inValid <= 1'b0;
    while (outValid !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    repeat (stall) @(posedge core_clk);
    outReady <= 1'b1;
    if (stall != 0) begin
      @(posedge core_clk);
    end
    check(n < 50, 1'b1);
    check(outHdrValid, eHdr);
    check(outDistValid, eDist);
    check(outReadLen, rdLen);
    check(outPoint, pt);
    check(outHandle, inHandle);
    if (eHdr) begin
      check({outPosX, outPosY, outPosZ}, {32'h3F80_0000, 32'h4000_0000, 32'h3F00_0000});
      check(outVpIndex, eVp);
      check(outRtai, DW1[10:0]);
      check(outPointWidth, topo ? DW3[18:8] : 11'h000);
      check(outClipCodes, pt ? 8'h00 : (DW3[7:0] & ucMask));
      check(outRhw, 32'h3E80_0000);
    end
    if (eDist) begin
      check(outClipDist, distRow);
    end
  endtask : vtx
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failCount++;
      wrapUp();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(REG_CTRL, 32'h3);
    rd(REG_MAXVP, 32'hF);
    rd(REG_UCMASK, 32'hFF);
    rd(REG_RDLEN, 32'h1);
    rd(8'h20, 32'h0);
    wr(REG_MAXVP, 32'h5);
    wr(REG_UCMASK, 32'hF);
    ucMask = 8'h0F;
    vtx(1'b0, 1'b0, 1'b1, 32'h5, 1'b1, 4'h5, 1'b0, 0);
    vtx(1'b0, 1'b0, 1'b0, 32'h6, 1'b1, 4'h0, 1'b0, 3);
    rd(REG_STATUS, 32'h2);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS, 32'h0);
    wr(REG_CTRL, 32'h2);
    vtx(1'b0, 1'b0, 1'b0, 32'hF, 1'b1, 4'hF, 1'b0, 0);
    vtx(1'b0, 1'b0, 1'b1, 32'h10, 1'b1, 4'h0, 1'b0, 0);
    vtx(1'b1, 1'b1, 1'b1, 32'hC, 1'b1, 4'hC, 1'b0, 0);
    vtx(1'b1, 1'b0, 1'b1, 32'h9, 1'b0, 4'h0, 1'b0, 0);
    rd(REG_HCOUNT, 32'h5);
    rd(REG_VCOUNT, 32'h6);
    wr(REG_CTRL, 32'h0);
    vtx(1'b1, 1'b1, 1'b0, 32'h4, 1'b0, 4'h0, 1'b0, 0);
    wr(REG_RDLEN, 32'h40);
    rdLen = 6'h3F;
    rd(REG_RDLEN, 32'h3F);
    rd(REG_STATUS, 32'h3);
    vtx(1'b0, 1'b0, 1'b0, 32'h3, 1'b1, 4'h3, 1'b0, 0);
    wr(REG_RDLEN, 32'h2);
    rdLen = 6'h02;
    wr(REG_CTRL, 32'h7);
    latency <= 4'h5;
    vtx(1'b0, 1'b0, 1'b1, 32'h4, 1'b1, 4'h4, 1'b1, 2);
    wrapUp();
  end
endmodule : vhr_readback_tb
`default_nettype wire
